// file: design/battery_charge_map.vh
// offsets, field positions, reset values and timing counts of the charge sequencer
`ifndef BATTERY_CHARGE_MAP_VH
`define BATTERY_CHARGE_MAP_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_FREQ_HZ 200000000
// timer tick period in milliseconds
`define TICK_PERIOD_MS 1000
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)
// state timeouts in tenths of a minute
`define PREQUAL_TIME_DMIN 75
`define FAST_TIME_DMIN 900
`define FULL_TIME_DMIN 900
`define TOPOFF_TIME_DMIN 450
// ticks per tenth of a minute
`define TICKS_PER_DMIN (6000 / `TICK_PERIOD_MS)
`define PREQUAL_TC (`PREQUAL_TIME_DMIN * `TICKS_PER_DMIN)
`define FAST_TC (`FAST_TIME_DMIN * `TICKS_PER_DMIN)
`define FULL_TC (`FULL_TIME_DMIN * `TICKS_PER_DMIN)
`define TOPOFF_TC (`TOPOFF_TIME_DMIN * `TICKS_PER_DMIN)
// full and fast periods over the prequal period
`define LONG_PERIOD_RATIO 4'd12
// temperature measurement rate in hundredths of a hertz
`define TEMP_RATE_CHZ 112
`define TEMP_PERIOD_CYCLES ((`CLK_FREQ_HZ / `TEMP_RATE_CHZ) * 100)
// charging halted this long per measurement, microseconds
`define TEMP_MEAS_US 10
`define TEMP_MEAS_CYCLES ((`CLK_FREQ_HZ / 1000000) * `TEMP_MEAS_US)

// ----------------------------------------
// widths
// ----------------------------------------
`define TIMER_W 13
`define PRESCALE_W 28

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_TIMERS 4'h8
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'b1
`define STATUS_STATE_LSB 0
`define STATUS_TEMP_OK_BIT 4
`define STATUS_TEMP_HOT_BIT 5
`define STATUS_MEAS_BIT 6
`define STATUS_MODE_LSB 8
`define TIMERS_SHORT_LSB 0
`define TIMERS_FAST_LSB 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ----------------------------------------
// current modes
// ----------------------------------------
`define MODE_OFF 2'h0
`define MODE_TENTH 2'h1
`define MODE_CC 2'h2
`define MODE_CV 2'h3

`endif

// file: design/charge_timer.v
// tick prescaler and freezable timeout counter
`timescale 1ns/1ps
`include "battery_charge_map.vh"

module charge_timer #(
	parameter [`PRESCALE_W-1:0] TICK_CYCLES = `TICK_CYCLES
) (
	input wire core_clk,
	input wire resetn,
	input wire clear,
	input wire run,
	input wire [`TIMER_W-1:0] terminal,
	output reg [`TIMER_W-1:0] count,
	output reg expired
);

	reg [`PRESCALE_W-1:0] prescale;
	wire tick;

	assign tick = run && (prescale == TICK_CYCLES - 1'b1);

	// ----------------------------------------
	// fixed-rate tick, held while frozen
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prescale <= {`PRESCALE_W{1'b0}};
		end else if (clear || tick) begin
			prescale <= {`PRESCALE_W{1'b0}};
		end else if (run) begin
			prescale <= prescale + 1'b1;
		end
	end

	// ----------------------------------------
	// tick counter against terminal count
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count <= {`TIMER_W{1'b0}};
			expired <= 1'b0;
		end else if (clear) begin
			count <= {`TIMER_W{1'b0}};
			expired <= 1'b0;
		end else begin
			if (tick && !expired) begin
				count <= count + 1'b1;
			end
			expired <= (count >= terminal);
		end
	end

endmodule

// file: design/battery_charge_sequencer.v
// charge-control state machine with axi4-lite status and control
// How it works
// - power-up or disable release: reset, timers cleared
// - reset: zero current, indicators released high
// - dropout, overvoltage, or recharge from done: reset
// - supplies, reference, bias good: go prequalify
// - prequalify: tenth current, constant-current indicator low
// - above undervoltage, temperature ok: fast charge
// - prequal timeout while undervoltage: fault, stop
// - fast charge: constant current, indicator, fast timer
// - regulation voltage reached in time: full charge
// - fast timer expires first: fault, stop
// - full charge: constant voltage, indicator, short timer
// - low current or full timeout: top-off
// - top-off: voltage mode, indicators high, then done
// - done: zero current until below recharge
// - temperature out: zero current, timers frozen, resume
// - reset with battery too hot: fault
// - fault: zero current, fault indicator low
// - fault left only by power or disable
// - disabled: no charging, outputs floated, then reset
// - temperature sampled 1.12 per second, charging paused
`timescale 1ns/1ps
`include "battery_charge_map.vh"

module battery_charge_sequencer #(
	parameter [`PRESCALE_W-1:0] SHORT_TICK_CYCLES = `TICK_CYCLES,
	parameter [`PRESCALE_W-1:0] FAST_TICK_CYCLES = `TICK_CYCLES,
	parameter [`PRESCALE_W-1:0] TEMP_PERIOD_CYCLES = `TEMP_PERIOD_CYCLES,
	parameter [`TIMER_W-1:0] PREQUAL_TC = `PREQUAL_TC,
	parameter [`TIMER_W-1:0] TOPOFF_TC = `TOPOFF_TC
) (
	input wire core_clk,
	input wire resetn,
	input wire chargerDisableN,
	input wire inputPowerGood,
	input wire referenceGood,
	input wire biasGood,
	input wire battUnderVoltage,
	input wire battAtRegulation,
	input wire chargeCurrentLow,
	input wire battBelowRecharge,
	input wire inputDropout,
	input wire battOverVoltage,
	input wire tempInWindow,
	input wire tempAtMax,
	output reg [1:0] currentMode,
	output reg constCurrentIndicatorOut,
	output reg constCurrentIndicatorOe,
	output reg constVoltageIndicatorOut,
	output reg constVoltageIndicatorOe,
	output reg faultIndicatorOut,
	output reg faultIndicatorOe,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [2:0] ST_RESET = 3'h0;
	localparam [2:0] ST_PREQUAL = 3'h1;
	localparam [2:0] ST_FAST = 3'h2;
	localparam [2:0] ST_FULL = 3'h3;
	localparam [2:0] ST_TOPOFF = 3'h4;
	localparam [2:0] ST_DONE = 3'h5;
	localparam [2:0] ST_SUSPEND = 3'h6;
	localparam [2:0] ST_FAULT = 3'h7;
	localparam [`PRESCALE_W-1:0] MEAS_CYCLES = `TEMP_MEAS_CYCLES;
	// long periods locked to twelve prequal periods
	localparam [`TIMER_W-1:0] FAST_TC = PREQUAL_TC * `LONG_PERIOD_RATIO;
	localparam [`TIMER_W-1:0] FULL_TC = PREQUAL_TC * `LONG_PERIOD_RATIO;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [2:0] resumeState;
	reg swEnable;
	reg [`PRESCALE_W-1:0] tempCount;
	reg measuring;
	reg tempOk;
	reg tempHot;
	reg [3:0] wrAddr;
	reg awHeld;
	reg [31:0] wrData;
	reg [3:0] wrStrb;
	reg wHeld;
	reg next_ccOe;
	reg next_cvOe;
	reg next_faultOe;
	reg [1:0] next_mode;
	wire enabled;
	wire shortExpired;
	wire fastExpired;
	wire timerClear;
	wire shortRun;
	wire fastRun;
	wire [`TIMER_W-1:0] shortCount;
	wire [`TIMER_W-1:0] fastCount;
	wire [`TIMER_W-1:0] shortTerminal;

	// a state that charges and may be suspended
	function isCharging;
		input [2:0] s;
		begin
			isCharging = (s == ST_PREQUAL) || (s == ST_FAST) ||
				(s == ST_FULL) || (s == ST_TOPOFF);
		end
	endfunction

	// register read decode
	function [31:0] readWord;
		input [3:0] addr;
		begin
			case (addr)
				`ADDR_CTRL: readWord = {31'h0, swEnable};
				`ADDR_STATUS: readWord = {22'h0, currentMode, 1'b0, measuring,
					tempHot, tempOk, 1'b0, state};
				`ADDR_TIMERS: readWord = {3'h0, fastCount, 3'h0, shortCount};
				default: readWord = 32'h0;
			endcase
		end
	endfunction

	function isMapped;
		input [3:0] addr;
		begin
			isMapped = (addr == `ADDR_CTRL) || (addr == `ADDR_STATUS) ||
				(addr == `ADDR_TIMERS);
		end
	endfunction

	assign enabled = chargerDisableN && swEnable;

	// ----------------------------------------
	// safety timers
	// ----------------------------------------
	assign timerClear = !enabled || (state == ST_RESET) ||
		((next_state != state) && (next_state != ST_SUSPEND) &&
		(state != ST_SUSPEND));
	assign shortRun = enabled && !measuring &&
		((state == ST_PREQUAL) || (state == ST_FULL) || (state == ST_TOPOFF));
	assign fastRun = enabled && !measuring && (state == ST_FAST);
	assign shortTerminal = (state == ST_PREQUAL) ? PREQUAL_TC :
		((state == ST_FULL) ? FULL_TC : TOPOFF_TC);

	charge_timer #(
		.TICK_CYCLES(SHORT_TICK_CYCLES)
	) shortPeriodTimer (
		.core_clk(core_clk),
		.resetn(resetn),
		.clear(timerClear),
		.run(shortRun),
		.terminal(shortTerminal),
		.count(shortCount),
		.expired(shortExpired)
	);

	charge_timer #(
		.TICK_CYCLES(FAST_TICK_CYCLES)
	) fastPeriodTimer (
		.core_clk(core_clk),
		.resetn(resetn),
		.clear(timerClear),
		.run(fastRun),
		.terminal(FAST_TC),
		.count(fastCount),
		.expired(fastExpired)
	);

	// ----------------------------------------
	// temperature measurement
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tempCount <= {`PRESCALE_W{1'b0}};
			measuring <= 1'b0;
			tempOk <= 1'b1;
			tempHot <= 1'b0;
		end else begin
			if (tempCount == TEMP_PERIOD_CYCLES - 1'b1) begin
				tempCount <= {`PRESCALE_W{1'b0}};
			end else begin
				tempCount <= tempCount + 1'b1;
			end
			measuring <= (tempCount < MEAS_CYCLES);
			if (measuring && (tempCount == MEAS_CYCLES)) begin
				tempOk <= tempInWindow;
				tempHot <= tempAtMax;
			end
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always @* begin
		next_state = state;
		if (!enabled) begin
			next_state = ST_RESET;
		end else if ((inputDropout || battOverVoltage) && (state != ST_FAULT)) begin
			next_state = ST_RESET;
		end else begin
			case (state)
				ST_RESET: begin
					if (tempHot) begin
						next_state = ST_FAULT;
					end else if (inputPowerGood && referenceGood && biasGood) begin
						next_state = ST_PREQUAL;
					end
				end
				ST_PREQUAL: begin
					if (shortExpired && battUnderVoltage) begin
						next_state = ST_FAULT;
					end else if (!tempOk) begin
						next_state = ST_SUSPEND;
					end else if (!battUnderVoltage) begin
						next_state = ST_FAST;
					end
				end
				ST_FAST: begin
					if (fastExpired) begin
						next_state = ST_FAULT;
					end else if (!tempOk) begin
						next_state = ST_SUSPEND;
					end else if (battAtRegulation) begin
						next_state = ST_FULL;
					end
				end
				ST_FULL: begin
					if (chargeCurrentLow || shortExpired) begin
						next_state = ST_TOPOFF;
					end else if (!tempOk) begin
						next_state = ST_SUSPEND;
					end
				end
				ST_TOPOFF: begin
					if (shortExpired) begin
						next_state = ST_DONE;
					end else if (!tempOk) begin
						next_state = ST_SUSPEND;
					end
				end
				ST_DONE: begin
					if (battBelowRecharge) begin
						next_state = ST_RESET;
					end
				end
				ST_SUSPEND: begin
					if (tempOk) begin
						next_state = resumeState;
					end
				end
				ST_FAULT: begin
					next_state = ST_FAULT;
				end
				default: begin
					next_state = ST_RESET;
				end
			endcase
		end
	end

	// ----------------------------------------
	// outputs per state
	// ----------------------------------------
	always @* begin
		next_ccOe = 1'b0;
		next_cvOe = 1'b0;
		next_faultOe = 1'b0;
		next_mode = `MODE_OFF;
		case (next_state)
			ST_PREQUAL: begin
				next_ccOe = 1'b1;
				next_mode = `MODE_TENTH;
			end
			ST_FAST: begin
				next_ccOe = 1'b1;
				next_mode = `MODE_CC;
			end
			ST_FULL: begin
				next_cvOe = 1'b1;
				next_mode = `MODE_CV;
			end
			ST_TOPOFF: begin
				next_mode = `MODE_CV;
			end
			ST_SUSPEND: begin
				next_ccOe = constCurrentIndicatorOe;
				next_cvOe = constVoltageIndicatorOe;
				next_faultOe = faultIndicatorOe;
			end
			ST_FAULT: begin
				next_faultOe = 1'b1;
			end
			default: begin
				next_mode = `MODE_OFF;
			end
		endcase
		if (!enabled) begin
			next_ccOe = 1'b0;
			next_cvOe = 1'b0;
			next_faultOe = 1'b0;
		end
		if (tempCount < MEAS_CYCLES) begin
			next_mode = `MODE_OFF;
		end
	end

	// ----------------------------------------
	// state and output registers
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_RESET;
			resumeState <= ST_PREQUAL;
			currentMode <= `MODE_OFF;
			constCurrentIndicatorOe <= 1'b0;
			constVoltageIndicatorOe <= 1'b0;
			faultIndicatorOe <= 1'b0;
			constCurrentIndicatorOut <= 1'b0;
			constVoltageIndicatorOut <= 1'b0;
			faultIndicatorOut <= 1'b0;
		end else begin
			state <= next_state;
			if ((next_state == ST_SUSPEND) && isCharging(state)) begin
				resumeState <= state;
			end
			currentMode <= next_mode;
			constCurrentIndicatorOe <= next_ccOe;
			constVoltageIndicatorOe <= next_cvOe;
			faultIndicatorOe <= next_faultOe;
			constCurrentIndicatorOut <= 1'b0;
			constVoltageIndicatorOut <= 1'b0;
			faultIndicatorOut <= 1'b0;
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrAddr <= 4'h0;
			wrData <= 32'h0;
			wrStrb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			swEnable <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				wrAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (awHeld && wHeld && !s_axi_bvalid) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= isMapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
				if ((wrAddr == `ADDR_CTRL) && wrStrb[0]) begin
					swEnable <= wrData[`CTRL_ENABLE_BIT];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readWord(s_axi_araddr);
				s_axi_rresp <= isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// file: sim/battery_charge_sequencer_checker.sv
// concurrent checks on the charge sequencer ports
`timescale 1ns/1ps
`include "battery_charge_map.vh"
module battery_charge_sequencer_checker (
	input wire core_clk,
	input wire resetn,
	input wire chargerDisableN,
	input wire inputDropout,
	input wire battOverVoltage,
	input wire [1:0] currentMode,
	input wire constCurrentIndicatorOe,
	input wire constVoltageIndicatorOe,
	input wire faultIndicatorOe,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence sWriteTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence sIdleOut;
		!constCurrentIndicatorOe && !constVoltageIndicatorOe && currentMode == `MODE_OFF;
	endsequence
	a_disable_idle: assert property (!chargerDisableN |=> sIdleOut ##0 !faultIndicatorOe)
		else $error("outputs active while disabled");
	a_dropout_reset: assert property ((inputDropout || battOverVoltage) && !faultIndicatorOe |=> sIdleOut)
		else $error("no reset on dropout or overvoltage");
	a_fault_outputs: assert property (faultIndicatorOe |-> sIdleOut)
		else $error("fault with current or indicator");
	a_cc_cv_apart: assert property (!(constCurrentIndicatorOe && constVoltageIndicatorOe))
		else $error("both mode indicators low");
	a_tenth_shows_cc: assert property (currentMode == `MODE_TENTH |-> constCurrentIndicatorOe)
		else $error("tenth current without indicator");
	a_cc_shows_cc: assert property (currentMode == `MODE_CC |-> constCurrentIndicatorOe)
		else $error("constant current without indicator");
	a_cv_mode_only: assert property (constVoltageIndicatorOe |-> currentMode[0] == currentMode[1])
		else $error("voltage indicator in wrong mode");
	a_fault_sticky: assert property (faultIndicatorOe && chargerDisableN |=> faultIndicatorOe)
		else $error("fault left without disable");
	a_write_answer: assert property (sWriteTaken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule
bind battery_charge_sequencer battery_charge_sequencer_checker chk (.*);

// file: sim/indicator_led_model.sv
// status pins with pull-ups as seen by the leds
`timescale 1ns/1ps
module indicator_led_model (
	input wire ccOe,
	input wire ccOut,
	input wire cvOe,
	input wire cvOut,
	input wire fOe,
	input wire fOut,
	output wire [2:0] pinLevel
);
	// ----------------------------------------
	// open-drain resolution, released pin pulled high
	// ----------------------------------------
	assign pinLevel[2] = ccOe ? ccOut : 1'b1;
	assign pinLevel[1] = cvOe ? cvOut : 1'b1;
	assign pinLevel[0] = fOe ? fOut : 1'b1;
endmodule

// file: sim/battery_charge_sequencer_tb.sv
// self-checking bench of the charge sequencer
`timescale 1ns/1ps
`include "battery_charge_map.vh"
module battery_charge_sequencer_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic core_clk = 1'b0, resetn = 1'b0, chargerDisableN = 1'b1;
	logic inputPowerGood = 1'b0, referenceGood = 1'b0, biasGood = 1'b0;
	logic battUnderVoltage = 1'b1, battAtRegulation = 1'b0, chargeCurrentLow = 1'b0;
	logic battBelowRecharge = 1'b0, inputDropout = 1'b0, battOverVoltage = 1'b0;
	logic tempInWindow = 1'b1, tempAtMax = 1'b0;
	logic [1:0] currentMode, s_axi_bresp, s_axi_rresp, rs;
	logic constCurrentIndicatorOut, constCurrentIndicatorOe, constVoltageIndicatorOut;
	logic constVoltageIndicatorOe, faultIndicatorOut, faultIndicatorOe;
	logic [2:0] pins;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, held;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int errCount = 0, cmpCount = 0, cycles = 0;
	battery_charge_sequencer #(.SHORT_TICK_CYCLES(28'd40), .FAST_TICK_CYCLES(28'd40),
		.TEMP_PERIOD_CYCLES(28'd3000), .PREQUAL_TC(13'd3),
		.TOPOFF_TC(13'd18)) DUT (.*);
	indicator_led_model leds (.ccOe(constCurrentIndicatorOe), .ccOut(constCurrentIndicatorOut),
		.cvOe(constVoltageIndicatorOe), .cvOut(constVoltageIndicatorOut),
		.fOe(faultIndicatorOe), .fOut(faultIndicatorOut), .pinLevel(pins));
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			errCount++;
			tallyAndFinish();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tallyAndFinish;
		$display("comparisons %0d mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge core_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, `RESP_OKAY);
	endtask
	task automatic axiRead(input logic [3:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic check(input logic [2:0] st, input logic [1:0] mode, input logic [2:0] pinExp);
		axiRead(`ADDR_STATUS);
		chk(rd[2:0], st);
		chk(rd[9:8], rd[6] ? `MODE_OFF : mode);
		chk(pins, pinExp);
	endtask
	task automatic waitState(input logic [2:0] st);
		int n;
		n = 0;
		do begin
			axiRead(`ADDR_STATUS);
			n++;
		end while (rd[2:0] !== st && n < 4000);
		chk(rd[2:0], st);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic tReset;
		check(3'd0, `MODE_OFF, 3'b111);
		axiRead(`ADDR_TIMERS);
		chk(rd, 32'h0);
		axiRead(`ADDR_CTRL);
		chk(rd[0], `CTRL_RESET);
		axiRead(4'hc);
		chk({rs, rd}, {`RESP_SLVERR, 32'h0});
		axiWrite(`ADDR_STATUS, 32'hffffffff);
		check(3'd0, `MODE_OFF, 3'b111);
	endtask
	task automatic tHotStart;
		tempAtMax <= 1'b1;
		repeat (3100) @(posedge core_clk);
		{inputPowerGood, referenceGood, biasGood} <= 3'b111;
		waitState(3'd7);
		check(3'd7, `MODE_OFF, 3'b110);
		tempAtMax <= 1'b0;
		inputDropout <= 1'b1;
		repeat (3100) @(posedge core_clk);
		check(3'd7, `MODE_OFF, 3'b110);
		inputDropout <= 1'b0;
	endtask
	task automatic tDisable;
		chargerDisableN <= 1'b0;
		repeat (3) @(posedge core_clk);
		check(3'd0, `MODE_OFF, 3'b111);
		chk(currentMode, `MODE_OFF);
		chargerDisableN <= 1'b1;
		waitState(3'd1);
		check(3'd1, `MODE_TENTH, 3'b011);
	endtask
	task automatic tPrequalTimeout;
		waitState(3'd7);
		check(3'd7, `MODE_OFF, 3'b110);
		chargerDisableN <= 1'b0;
		repeat (2) @(posedge core_clk);
		battUnderVoltage <= 1'b0;
		chargerDisableN <= 1'b1;
	endtask
	task automatic tFastSuspend;
		waitState(3'd2);
		check(3'd2, `MODE_CC, 3'b011);
		axiWrite(`ADDR_CTRL, 32'h0);
		check(3'd0, `MODE_OFF, 3'b111);
		axiWrite(`ADDR_CTRL, 32'h1);
		waitState(3'd2);
		tempInWindow <= 1'b0;
		waitState(3'd6);
		check(3'd6, `MODE_OFF, 3'b011);
		axiRead(`ADDR_TIMERS);
		held = rd;
		repeat (400) @(posedge core_clk);
		axiRead(`ADDR_TIMERS);
		chk(rd, held);
		tempInWindow <= 1'b1;
		waitState(3'd2);
		axiRead(`ADDR_TIMERS);
		chk(rd[28:16] >= held[28:16], 1'b1);
		waitState(3'd7);
		check(3'd7, `MODE_OFF, 3'b110);
		chargerDisableN <= 1'b0;
		@(posedge core_clk);
		chargerDisableN <= 1'b1;
	endtask
	task automatic tFullFlow;
		battAtRegulation <= 1'b1;
		waitState(3'd3);
		check(3'd3, `MODE_CV, 3'b101);
		do axiRead(`ADDR_STATUS); while (rd[6] !== 1'b1);
		chk(rd[9:8], `MODE_OFF);
		do axiRead(`ADDR_STATUS); while (rd[6] !== 1'b0);
		chk(rd[9:8], `MODE_CV);
		chargeCurrentLow <= 1'b1;
		waitState(3'd4);
		check(3'd4, `MODE_CV, 3'b111);
		waitState(3'd5);
		check(3'd5, `MODE_OFF, 3'b111);
		{battUnderVoltage, battAtRegulation, chargeCurrentLow} <= 3'b100;
		battBelowRecharge <= 1'b1;
		waitState(3'd1);
		battBelowRecharge <= 1'b0;
	endtask
	task automatic tDropout;
		for (int i = 0; i < 2; i++) begin
			{inputDropout, battOverVoltage} <= i ? 2'b01 : 2'b10;
			repeat (2) @(posedge core_clk);
			check(3'd0, `MODE_OFF, 3'b111);
			{inputDropout, battOverVoltage} <= 2'b00;
			waitState(3'd1);
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		tReset();
		tHotStart();
		tDisable();
		tPrequalTimeout();
		tFastSuspend();
		tFullFlow();
		tDropout();
		tallyAndFinish();
	end
endmodule
